//--- rtl/ats_seq.sv
`timescale 1ns/100ps
`include "ats_params.svh"

module ats_seq (
  input  wire logic                      ref_clk,
  input  wire logic                      sys_rst,
  input  wire ats_pkg::ats_cfg_t         cfg_src,
  input  wire ats_pkg::ats_cfg_t         cfg_meas,
  input  wire logic [`ATS_NCH-1:0]       init_req,
  input  wire logic                      run_auto,
  input  wire logic                      bus_trigger,
  input  wire logic                      internal_line_one,
  input  wire logic                      internal_line_two,
  input  wire logic [`ATS_NDIO-1:0]      dio_pin_event,
  input  wire logic                      lan_trigger,
  input  wire logic                      trigger_input_jack,
  output logic                           src_apply,
  output logic                           meas_start,
  output ats_pkg::ats_stat_t             stat_src,
  output ats_pkg::ats_stat_t             stat_meas
);

  ats_pkg::ats_top_t               q_r;
  ats_pkg::ats_top_t               q_nxt;
  ats_pkg::ats_cfg_t [`ATS_NCH-1:0] cfg_in;
  ats_pkg::ats_cfg_t [`ATS_NCH-1:0] cfg_use;
  ats_pkg::ats_cfg_t               cfg_free;
  logic [`ATS_NLINE-1:0]           lines;
  logic [`ATS_NLINE-1:0]           line_rise;
  logic [`ATS_NCH-1:0]             tmr_tick;
  logic [`ATS_NCH-1:0]             arm_ev;
  logic [`ATS_NCH-1:0]             trig_ev;
  logic [`ATS_NCH-1:0]             force_idle;
  logic [`ATS_NCH-1:0]             start;

  // Per-copy delay and loop end decodes
  logic [`ATS_NCH-1:0]             arm_dly_done;
  logic [`ATS_NCH-1:0]             trig_dly_done;
  logic [`ATS_NCH-1:0]             act_dly_done;
  logic [`ATS_NCH-1:0]             last_trig;
  logic [`ATS_NCH-1:0]             last_arm;

  // Per-copy status before it is split onto the two ports
  ats_pkg::ats_stat_t [`ATS_NCH-1:0] stat_ch;

  // Line inputs gathered and edge detected; bus and LAN arrive as pulses
  assign lines     = {trigger_input_jack, dio_pin_event, internal_line_two, internal_line_one};
  assign line_rise = lines & ~q_r.line_prev;
  assign cfg_in    = {cfg_meas, cfg_src};

  // Preset conditions for free-running measurement
  always_comb begin
    cfg_free              = '0;
    cfg_free.arm_src      = ats_pkg::ATS_SRC_AUTO;
    cfg_free.trig_src     = ats_pkg::ATS_SRC_AUTO;
    cfg_free.arm_count    = `ATS_CNT_ONE;
    cfg_free.trig_count   = `ATS_CNT_ONE;
    cfg_free.timer_period = `ATS_DLY_ONE;
    // No waiting between layers, so the loop restarts quickly
    cfg_free.arm_delay    = `ATS_DLY_ZERO;
    cfg_free.trig_delay   = `ATS_DLY_ZERO;
    cfg_free.act_delay    = `ATS_DLY_ZERO;
  end

  // Event from the selected source; auto fires at once in this mode
  function automatic logic pick_event(input ats_pkg::ats_src_t src,
                                      input logic [`ATS_NLINE-1:0] rise,
                                      input logic bus_ev,
                                      input logic lan_ev,
                                      input logic tick);
    logic [`ATS_SRC_W-1:0] idx;
    idx = src - `ATS_LINE_BASE;
    if (src == ats_pkg::ATS_SRC_AUTO) begin
      pick_event = 1'b1;
    end else if (src == ats_pkg::ATS_SRC_BUS) begin
      pick_event = bus_ev;
    end else if (src == ats_pkg::ATS_SRC_TIMER) begin
      pick_event = tick;
    // Internal bus lines, rising edge only
    end else if (src == ats_pkg::ATS_SRC_LINE1) begin
      pick_event = rise[idx];
    end else if (src == ats_pkg::ATS_SRC_LINE2) begin
      pick_event = rise[idx];
    // Digital pins 1 to 7 sit right after the lines
    end else if (src == ats_pkg::ATS_SRC_DIO1) begin
      pick_event = rise[idx];
    end else if (src == ats_pkg::ATS_SRC_DIO2) begin
      pick_event = rise[idx];
    end else if (src == ats_pkg::ATS_SRC_DIO3) begin
      pick_event = rise[idx];
    end else if (src == ats_pkg::ATS_SRC_DIO4) begin
      pick_event = rise[idx];
    end else if (src == ats_pkg::ATS_SRC_DIO5) begin
      pick_event = rise[idx];
    end else if (src == ats_pkg::ATS_SRC_DIO6) begin
      pick_event = rise[idx];
    end else if (src == ats_pkg::ATS_SRC_DIO7) begin
      pick_event = rise[idx];
    // Network message arrives as a ready-made pulse
    end else if (src == ats_pkg::ATS_SRC_LAN) begin
      pick_event = lan_ev;
    end else if (src == ats_pkg::ATS_SRC_TIN) begin
      pick_event = rise[`ATS_TIN_BIT];
    end else begin
      pick_event = 1'b0;
    end
  endfunction : pick_event

  // Per-channel configuration choice, timer tick and layer events
  for (genvar i = 0; i < `ATS_NCH; i++) begin : g_ch
    assign cfg_use[i] = (i == `ATS_CH_MEAS && q_r.free_run) ? cfg_free : cfg_in[i];
    assign tmr_tick[i] = (q_r.ch[i].tmr_cnt + `ATS_DLY_ONE) >= cfg_use[i].timer_period;
    assign arm_ev[i]  = pick_event(cfg_use[i].arm_src, line_rise, bus_trigger,
                                   lan_trigger, tmr_tick[i]);
    assign trig_ev[i] = pick_event(cfg_use[i].trig_src, line_rise, bus_trigger,
                                   lan_trigger, tmr_tick[i]);
    // Source copy is off in free run; measurement is forced idle for a cycle on a mode change
    assign force_idle[i] = (i == `ATS_CH_SRC) ? run_auto
                                               : (run_auto != q_r.free_run);
    assign start[i] = (i == `ATS_CH_MEAS && q_r.free_run) ? 1'b1 : init_req[i];

    // Delay counters compare against the programmed cycle counts
    assign arm_dly_done[i]  = q_r.ch[i].dly_cnt >= cfg_use[i].arm_delay;
    assign trig_dly_done[i] = q_r.ch[i].dly_cnt >= cfg_use[i].trig_delay;
    assign act_dly_done[i]  = q_r.ch[i].dly_cnt >= cfg_use[i].act_delay;

    // Loop ends; a count of zero behaves as one
    assign last_trig[i] = (q_r.ch[i].trig_cnt + `ATS_CNT_ONE) >= cfg_use[i].trig_count;
    assign last_arm[i]  = (q_r.ch[i].arm_cnt + `ATS_CNT_ONE) >= cfg_use[i].arm_count;

    // Layer and counter status of this copy
    assign stat_ch[i].idle        = q_r.ch[i].st == ats_pkg::ATS_ST_IDLE;
    assign stat_ch[i].arm_layer   = q_r.ch[i].st == ats_pkg::ATS_ST_ARM_WAIT
                                 || q_r.ch[i].st == ats_pkg::ATS_ST_ARM_DLY;
    assign stat_ch[i].trig_layer  = !stat_ch[i].idle && !stat_ch[i].arm_layer;
    assign stat_ch[i].arm_passes  = q_r.ch[i].arm_cnt;
    assign stat_ch[i].trig_cycles = q_r.ch[i].trig_cnt;
  end

  // Next-state logic for both sequencer copies
  always_comb begin
    ats_pkg::ats_ch_t c;
    logic [`ATS_CNT_W-1:0] trig_next;
    logic [`ATS_CNT_W-1:0] arm_next;
    c         = '0;
    trig_next = `ATS_CNT_ZERO;
    arm_next  = `ATS_CNT_ZERO;
    q_nxt           = q_r;
    q_nxt.line_prev = lines;
    q_nxt.free_run  = run_auto;
    for (int i = 0; i < `ATS_NCH; i++) begin
      c         = q_r.ch[i];
      c.act     = 1'b0;
      trig_next = c.trig_cnt + `ATS_CNT_ONE;
      arm_next  = c.arm_cnt + `ATS_CNT_ONE;
      // Interval timer runs only while the copy is active
      if (c.st == ats_pkg::ATS_ST_IDLE || tmr_tick[i]) begin
        c.tmr_cnt = `ATS_DLY_ZERO;
      end else begin
        c.tmr_cnt = c.tmr_cnt + `ATS_DLY_ONE;
      end
      case (c.st)
        // Idle: only an initiation leaves, and it restarts both counters
        ats_pkg::ATS_ST_IDLE: begin
          if (start[i] && !force_idle[i]) begin
            c.st       = ats_pkg::ATS_ST_ARM_WAIT;
            c.arm_cnt  = `ATS_CNT_ZERO;
            c.trig_cnt = `ATS_CNT_ZERO;
          end
        end
        // Arm layer: wait on the arm source
        ats_pkg::ATS_ST_ARM_WAIT: begin
          if (arm_ev[i]) begin
            c.st      = ats_pkg::ATS_ST_ARM_DLY;
            c.dly_cnt = `ATS_DLY_ZERO;
          end
        end
        // Arm delay: events are ignored until it runs out
        ats_pkg::ATS_ST_ARM_DLY: begin
          if (arm_dly_done[i]) begin
            c.st = ats_pkg::ATS_ST_TRIG_WAIT;
          end else begin
            c.dly_cnt = c.dly_cnt + `ATS_DLY_ONE;
          end
        end
        // Trigger layer: wait on the trigger source
        ats_pkg::ATS_ST_TRIG_WAIT: begin
          if (trig_ev[i]) begin
            c.st      = ats_pkg::ATS_ST_TRIG_DLY;
            c.dly_cnt = `ATS_DLY_ZERO;
          end
        end
        // Trigger delay, then the per-action delay
        ats_pkg::ATS_ST_TRIG_DLY: begin
          if (trig_dly_done[i]) begin
            c.st      = ats_pkg::ATS_ST_ACT_DLY;
            c.dly_cnt = `ATS_DLY_ZERO;
          end else begin
            c.dly_cnt = c.dly_cnt + `ATS_DLY_ONE;
          end
        end
        // Action delay: one pulse, then decide which loop continues
        ats_pkg::ATS_ST_ACT_DLY: begin
          if (act_dly_done[i]) begin
            c.act = 1'b1;
            if (last_trig[i]) begin
              c.trig_cnt = `ATS_CNT_ZERO;
              c.arm_cnt  = arm_next;
              if (last_arm[i]) begin
                c.st = ats_pkg::ATS_ST_IDLE;
              end else begin
                c.st = ats_pkg::ATS_ST_ARM_WAIT;
              end
            end else begin
              c.trig_cnt = trig_next;
              c.st       = ats_pkg::ATS_ST_TRIG_WAIT;
            end
          end else begin
            c.dly_cnt = c.dly_cnt + `ATS_DLY_ONE;
          end
        end
        // An illegal code falls back to idle
        default: begin
          c.st = ats_pkg::ATS_ST_IDLE;
        end
      endcase
      // Stop request ends the run without a further action
      if (force_idle[i]) begin
        c.st  = ats_pkg::ATS_ST_IDLE;
        c.act = 1'b0;
      end
      q_nxt.ch[i] = c;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q_r <= '0;
      for (int i = 0; i < `ATS_NCH; i++) begin
        q_r.ch[i].st <= ats_pkg::ATS_ST_IDLE;
      end
    end else begin
      q_r <= q_nxt;
    end
  end

  // Action strobes straight from flip-flops; status is decoded from the state register
  assign src_apply              = q_r.ch[`ATS_CH_SRC].act;
  assign meas_start             = q_r.ch[`ATS_CH_MEAS].act;

  // Status split per copy
  assign stat_src               = stat_ch[`ATS_CH_SRC];
  assign stat_meas              = stat_ch[`ATS_CH_MEAS];

endmodule : ats_seq

//--- rtl/ats_params.svh
`ifndef ATS_PARAMS_SVH
`define ATS_PARAMS_SVH

// Counter and delay widths
`define ATS_CNT_W      16
`define ATS_DLY_W      32
`define ATS_SRC_W      4
`define ATS_ST_W       6
`define ATS_NCH        2
`define ATS_NDIO       7
`define ATS_NLINE      10

// Channel indexes: source output and measurement
`define ATS_CH_SRC     0
`define ATS_CH_MEAS    1

// Sized constants used by the counters
`define ATS_CNT_ZERO   16'h0000
`define ATS_CNT_ONE    16'h0001
`define ATS_DLY_ZERO   32'h0000_0000
`define ATS_DLY_ONE    32'h0000_0001
`define ATS_LINE_ZERO  10'h000

// Offset from a line source code to its bit in the edge vector
`define ATS_LINE_BASE  4'h3
`define ATS_TIN_BIT    9

`endif

//--- rtl/ats_pkg.sv
`include "ats_params.svh"

package ats_pkg;

  // Event sources selectable per layer
  typedef enum logic [`ATS_SRC_W-1:0] {
    ATS_SRC_AUTO  = 4'h0,
    ATS_SRC_BUS   = 4'h1,
    ATS_SRC_TIMER = 4'h2,
    ATS_SRC_LINE1 = 4'h3,
    ATS_SRC_LINE2 = 4'h4,
    ATS_SRC_DIO1  = 4'h5,
    ATS_SRC_DIO2  = 4'h6,
    ATS_SRC_DIO3  = 4'h7,
    ATS_SRC_DIO4  = 4'h8,
    ATS_SRC_DIO5  = 4'h9,
    ATS_SRC_DIO6  = 4'ha,
    ATS_SRC_DIO7  = 4'hb,
    ATS_SRC_LAN   = 4'hc,
    ATS_SRC_TIN   = 4'hd
  } ats_src_t;

  // Sequencer layers, one-hot
  typedef enum logic [`ATS_ST_W-1:0] {
    ATS_ST_IDLE      = 6'h01,
    ATS_ST_ARM_WAIT  = 6'h02,
    ATS_ST_ARM_DLY   = 6'h04,
    ATS_ST_TRIG_WAIT = 6'h08,
    ATS_ST_TRIG_DLY  = 6'h10,
    ATS_ST_ACT_DLY   = 6'h20
  } ats_state_t;

  // Per-channel configuration, delays and period in clock cycles
  typedef struct packed {
    ats_src_t               arm_src;
    ats_src_t               trig_src;
    logic [`ATS_CNT_W-1:0]  arm_count;
    logic [`ATS_CNT_W-1:0]  trig_count;
    logic [`ATS_DLY_W-1:0]  arm_delay;
    logic [`ATS_DLY_W-1:0]  trig_delay;
    logic [`ATS_DLY_W-1:0]  act_delay;
    logic [`ATS_DLY_W-1:0]  timer_period;
  } ats_cfg_t;

  // Per-channel running state
  typedef struct packed {
    ats_state_t             st;
    logic [`ATS_CNT_W-1:0]  arm_cnt;
    logic [`ATS_CNT_W-1:0]  trig_cnt;
    logic [`ATS_DLY_W-1:0]  dly_cnt;
    logic [`ATS_DLY_W-1:0]  tmr_cnt;
    logic                   act;
  } ats_ch_t;

  // Whole module state
  typedef struct packed {
    ats_ch_t [`ATS_NCH-1:0]   ch;
    logic [`ATS_NLINE-1:0]    line_prev;
    logic                     free_run;
  } ats_top_t;

  // Per-channel status seen by software
  typedef struct packed {
    logic                   idle;
    logic                   arm_layer;
    logic                   trig_layer;
    logic [`ATS_CNT_W-1:0]  arm_passes;
    logic [`ATS_CNT_W-1:0]  trig_cycles;
  } ats_stat_t;

endpackage : ats_pkg

//--- bench/ats_seq_sva.sv
`timescale 1ns/100ps
`include "ats_params.svh"

module ats_seq_chk (
  input wire logic                ref_clk,
  input wire logic                sys_rst,
  input wire ats_pkg::ats_cfg_t   cfg_src,
  input wire ats_pkg::ats_cfg_t   cfg_meas,
  input wire logic [`ATS_NCH-1:0] init_req,
  input wire logic                run_auto,
  input wire logic                src_apply,
  input wire logic                meas_start,
  input wire ats_pkg::ats_stat_t  stat_src,
  input wire ats_pkg::ats_stat_t  stat_meas
);
  logic meas_quick;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Measurement copy on auto sources, single counts, no delays
  assign meas_quick = cfg_meas.arm_count < 16'h0002 && cfg_meas.trig_count < 16'h0002
    && {cfg_meas.arm_src, cfg_meas.trig_src, cfg_meas.arm_delay, cfg_meas.trig_delay,
        cfg_meas.act_delay} == 104'h0;
  property p_rst_idle;
    $fell(sys_rst) |-> stat_src.idle && stat_meas.idle && !src_apply && !meas_start;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("copies not idle");
  property p_init;
    init_req[0] && stat_src.idle && !run_auto && !$past(run_auto) |=> !stat_src.idle
      && stat_src.arm_layer && stat_src.arm_passes == 16'h0000 && stat_src.trig_cycles == 16'h0000;
  endproperty
  a_init: assert property (p_init) else $error("bad initiation");
  property p_quick;
    init_req[1] && stat_meas.idle && meas_quick && !run_auto && !$past(run_auto) |-> ##6 meas_start;
  endproperty
  a_quick: assert property (p_quick) else $error("measurement late");
  property p_end_src;
    $rose(stat_src.idle) && !$past(sys_rst) && !run_auto && !$past(run_auto) |-> src_apply
      && stat_src.arm_passes == (cfg_src.arm_count == 16'h0000 ? 16'h0001 : cfg_src.arm_count);
  endproperty
  a_end_src: assert property (p_end_src) else $error("bad run end");
  property p_bnd_src;
    !stat_src.idle |-> (stat_src.trig_cycles < cfg_src.trig_count || stat_src.trig_cycles == 16'h0000)
      && (stat_src.arm_passes < cfg_src.arm_count || stat_src.arm_passes == 16'h0000);
  endproperty
  a_bnd_src: assert property (p_bnd_src) else $error("count overrun");
  property p_free_src;
    run_auto && $past(run_auto) |-> !src_apply;
  endproperty
  a_free_src: assert property (p_free_src) else $error("source in free run");
  property p_free_meas;
    meas_start && run_auto ##1 run_auto [*6] |-> meas_start;
  endproperty
  a_free_meas: assert property (p_free_meas) else $error("free run gap");
  property p_indep;
    init_req == 2'b01 && stat_meas.idle && !run_auto && !$past(run_auto) |=> stat_meas.idle;
  endproperty
  a_indep: assert property (p_indep) else $error("copies coupled");
  property p_act_run;
    (src_apply |-> !$past(stat_src.idle)) and (meas_start |-> !$past(stat_meas.idle));
  endproperty
  a_act_run: assert property (p_act_run) else $error("action from idle");
endmodule : ats_seq_chk

bind ats_seq ats_seq_chk i_ats_seq_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .cfg_src(cfg_src), .cfg_meas(cfg_meas), .init_req(init_req), .run_auto(run_auto),
  .src_apply(src_apply), .meas_start(meas_start), .stat_src(stat_src), .stat_meas(stat_meas));

//--- bench/ats_far_model.sv
`timescale 1ns/100ps

module ats_far_model (
  input  wire logic              ref_clk,
  input  wire logic              fire,
  input  wire ats_pkg::ats_src_t sel,
  output logic [12:0]            ev_lines
);
  initial ev_lines = 13'h0000;
  // One-cycle event on the chosen source, bit i is code i+1; lines fall back low
  always @(posedge ref_clk) begin
    for (int i = 0; i < 13; i++) begin
      ev_lines[i] <= fire && (sel == 4'(i + 1));
    end
  end
endmodule : ats_far_model

//--- bench/tb_arm_trigger_sequencer.sv
`timescale 1ns/100ps
`include "ats_params.svh"

module tb_arm_trigger_sequencer;
  logic               ref_clk = 1'b0;
  logic               sys_rst;
  ats_pkg::ats_cfg_t  cfg_src;
  ats_pkg::ats_cfg_t  cfg_meas;
  logic [1:0]         init_req;
  logic               run_auto;
  logic               fire;
  ats_pkg::ats_src_t  sel;
  logic [12:0]        ev_lines;
  logic               src_apply;
  logic               meas_start;
  ats_pkg::ats_stat_t stat_src;
  ats_pkg::ats_stat_t stat_meas;
  logic [31:0]        q[$];
  int                 bcyc = 0;
  int                 mcyc = 0;
  int                 fr_n = 0;
  bit                 free = 1'b0;
  int                 fail_count = 0;
  int                 checks_done = 0;
  // Clock
  always #4 ref_clk = ~ref_clk;
  ats_seq i_ats_seq (.ref_clk(ref_clk), .sys_rst(sys_rst), .cfg_src(cfg_src),
    .cfg_meas(cfg_meas), .init_req(init_req), .run_auto(run_auto),
    .bus_trigger(ev_lines[0]), .internal_line_one(ev_lines[2]),
    .internal_line_two(ev_lines[3]), .dio_pin_event(ev_lines[10:4]),
    .lan_trigger(ev_lines[11]), .trigger_input_jack(ev_lines[12]), .src_apply(src_apply),
    .meas_start(meas_start), .stat_src(stat_src), .stat_meas(stat_meas));
  ats_far_model i_ats_far_model (.ref_clk(ref_clk), .fire(fire), .sel(sel), .ev_lines(ev_lines));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %0h got %0h", nm, exp, got);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic tick();
    @(posedge ref_clk);
    bcyc++;
  endtask : tick
  task automatic go(input int m);
    while (bcyc < m) tick();
  endtask : go
  // Auto and timer fire at once, others come from the far side after a lag
  task automatic fire_at(input logic [3:0] s, inout int t);
    int e;
    e = t + 2 + $urandom % 3;
    if (s == 4'h0 || s == 4'h2) e = t;
    else begin
      go(e - 1);
      sel <= ats_pkg::ats_src_t'(s);
      fire <= 1'b1;
      tick();
      fire <= 1'b0;
    end
    t = e;
  endtask : fire_at
  // One run of a copy; each action is noted with its cycle
  task automatic run(input bit ch, input logic [3:0] as, input logic [3:0] ts,
                     input logic [15:0] ac, input logic [15:0] tc, input int dm);
    ats_pkg::ats_cfg_t c;
    ats_pkg::ats_stat_t s;
    int t;
    c = '{ats_pkg::ats_src_t'(as), ats_pkg::ats_src_t'(ts), ac, tc, 32'($urandom % dm),
          32'($urandom % dm), 32'($urandom % dm), 32'h1};
    if (ch) cfg_meas <= c;
    else cfg_src <= c;
    tick();
    t = bcyc + 1;
    init_req[ch] <= 1'b1;
    go(t);
    init_req <= 2'b00;
    repeat ((ac == 0) ? 1 : ac) begin
      fire_at(as, t);
      t = t + 2 + c.arm_delay;
      repeat ((tc == 0) ? 1 : tc) begin
        fire_at(ts, t);
        t = t + 3 + c.trig_delay + c.act_delay;
        q.push_back({ch, 31'(t + 1)});
      end
    end
    go(t + 2);
    s = ch ? stat_meas : stat_src;
    chk("end", {1'b1, (ac == 0) ? 16'h0001 : ac}, {s.idle, s.arm_passes});
  endtask : run
  // Outside free run pair each action pulse with the oldest note; cut a hang short
  task automatic note(input bit ch);
    if (free) begin
      if (ch) fr_n++;
      else chk("free_src", 32'h0, 32'h1);
    end else if (q.size() == 0) chk("extra", 32'h0, {ch, 31'(mcyc)});
    else chk("pulse", q.pop_front(), {ch, 31'(mcyc)});
  endtask : note
  always @(posedge ref_clk) begin
    mcyc = mcyc + 1;
    if (mcyc > 8000) begin
      fail_count++;
      results();
    end
    if (src_apply === 1'b1) note(1'b0);
    if (meas_start === 1'b1) note(1'b1);
  end
  // Reset, every source code, counted loops, then free run
  initial begin
    void'($urandom(95597));
    sys_rst <= 1'b1;
    run_auto <= 1'b0;
    init_req <= 2'b00;
    fire <= 1'b0;
    sel <= ats_pkg::ATS_SRC_AUTO;
    cfg_src <= '0;
    cfg_meas <= '0;
    repeat (12) tick();
    sys_rst <= 1'b0;
    tick();
    chk("rst_idle", 32'h3, {stat_src.idle, stat_meas.idle});
    for (int k = 0; k < 14; k++) begin
      run(k[0], 4'($urandom % 14), 4'(k), 16'h1, 16'h1, 4);
    end
    run(1'b0, 4'h0, 4'h0, 16'h2, 16'h3, 3);
    run(1'b0, 4'h1, 4'hc, 16'h1, 16'h2, 2);
    run(1'b1, 4'h0, 4'h0, 16'h0, 16'h0, 1);
    free = 1'b1;
    run_auto <= 1'b1;
    init_req <= 2'b01;
    tick();
    init_req <= 2'b00;
    go(bcyc + 60);
    run_auto <= 1'b0;
    go(bcyc + 10);
    free = 1'b0;
    chk("free_meas", 32'h1, 32'(fr_n >= 8));
    chk("src_idle", 32'h1, 32'(stat_src.idle));
    chk("queue", 32'h0, 32'(q.size()));
    results();
  end
endmodule : tb_arm_trigger_sequencer
